// ==== rtl/trp_channel.sv ====
`timescale 1ns/100ps
module trp_channel #(
	parameter int CNT_W = trp_pkg::CNT_W,
	parameter int RETRY_LIMIT = trp_pkg::RETRY_LIMIT
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Control
	input wire logic request_i,
	input wire logic trip_i,
	input wire logic temp_ok_i,
	input wire logic supply_hold_ok_i,
	input wire logic supply_operate_ok_i,
	input wire logic count_enable_i,
	input wire logic react_rst_i,
	input wire logic clear_i,
	// Status
	output logic on_o,
	output logic latched_o,
	output logic trip_event_o,
	output logic [CNT_W-1:0] count_o
);
	localparam logic [CNT_W-1:0] LIMIT = CNT_W'(RETRY_LIMIT);

	trp_pkg::trp_state_e state;
	trp_pkg::trp_state_e next_state;
	logic [CNT_W-1:0] next_count;
	wire logic shut = state == trp_pkg::TRP_ON && trip_i;
	wire logic at_limit = count_o >= LIMIT;
	wire logic activate = state == trp_pkg::TRP_OFF && request_i &&
		supply_operate_ok_i;

	// Next state
	always_comb begin
		next_state = state;
		case (state)
			trp_pkg::TRP_OFF: begin
				if (activate)
					next_state = trp_pkg::TRP_ON;
			end
			trp_pkg::TRP_ON: begin
				if (trip_i)
					next_state = trp_pkg::TRP_COOL;
				else if (!supply_hold_ok_i || !request_i)
					next_state = trp_pkg::TRP_OFF;
			end
			trp_pkg::TRP_COOL: begin
				if (count_enable_i && at_limit)
					next_state = trp_pkg::TRP_LATCHED;
				else if (temp_ok_i)
					next_state = trp_pkg::TRP_OFF;
			end
			trp_pkg::TRP_LATCHED: begin
				if (clear_i)
					next_state = trp_pkg::TRP_OFF;
			end
			default: next_state = trp_pkg::TRP_OFF;
		endcase
		if (clear_i && state != trp_pkg::TRP_ON)
			next_state = trp_pkg::TRP_OFF;
	end

	// Retry counter
	always_comb begin
		next_count = count_o;
		if (activate && react_rst_i && !at_limit)
			next_count = trp_pkg::CNT_ZERO;
		if (shut && count_enable_i && !at_limit)
			next_count = count_o + trp_pkg::CNT_ONE;
		if (clear_i)
			next_count = trp_pkg::CNT_ZERO;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= trp_pkg::TRP_OFF;
			count_o <= trp_pkg::CNT_ZERO;
			on_o <= 1'b0;
			latched_o <= 1'b0;
			trip_event_o <= 1'b0;
		end else begin
			state <= next_state;
			count_o <= next_count;
			on_o <= next_state == trp_pkg::TRP_ON;
			latched_o <= next_state == trp_pkg::TRP_LATCHED;
			trip_event_o <= shut;
		end
	end
endmodule

// ==== rtl/trp_pkg.sv ====
package trp_pkg;
	// -------------------------------------------------------------
	// Geometry
	// -------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int RETRY_LIMIT = 8;
	localparam int CNT_W = 4;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// -------------------------------------------------------------
	// Register offsets (byte addresses)
	// -------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CFG = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_DIAG = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'hC;

	// Extra registers decoded directly at the unused offsets 0x1 and 0x2
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h2;

	// -------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------
	localparam int CFG_CLEAR_BIT = 0;
	localparam int CFG_REACT_RST_BIT = 1;
	localparam int DIAG_SUMMARY_BIT = 8;
	localparam int DIAG_OT_LSB = 4;

	// -------------------------------------------------------------
	// Reset values and counter increment
	// -------------------------------------------------------------
	localparam logic [NUM_CH-1:0] CH_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

	// Interrupt events: latch, thermal trip, undervoltage
	localparam int IRQ_W = 3;
	localparam int IRQ_LATCH = 0;
	localparam int IRQ_TRIP = 1;
	localparam int IRQ_UV = 2;

	// -------------------------------------------------------------
	// Channel states
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		TRP_OFF = 2'b00,
		TRP_ON = 2'b01,
		TRP_COOL = 2'b11,
		TRP_LATCHED = 2'b10
	} trp_state_e;

	// Sensor and supply indications
	typedef struct packed {
		logic [NUM_CH-1:0] abs_trip;
		logic [NUM_CH-1:0] dyn_trip;
		logic [NUM_CH-1:0] temp_ok;
		logic supply_hold_ok;
		logic supply_operate_ok;
		logic logic_supply_ok;
	} trp_sense_s;

	// Register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} trp_bus_s;
endpackage

// ==== rtl/trp_sync.sv ====
`timescale 1ns/100ps
module trp_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Data
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;

	// Two-stage synchroniser, first stage feeds only the second
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stage1 <= '0;
			sync_o <= '0;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule

// ==== rtl/trp_top.sv ====
// Function
// - Either thermal sensor trip turns channel off
// - Stay off until temperature is acceptable
// - Each protective turn-off adds one
// - At retry limit latch channel off
// - Clear bit resets all counters and flags
// - Requested channels restart right after clear
// - Reset-counter option zeroes count on activation
// - Limp-home counts only with valid logic supply
// - Limp-home without supply: unlimited restarts
// - Clear ignored in limp-home mode
// - Error state in both diagnosis reads
// - Overvoltage: outputs still follow requests
// - Below hold level force all off
// - Switch on only at operate level
// - Limp-home forces OR input combination
// - Summary bit set when any latched
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/100ps
module trp_top #(
	parameter int NUM_CH = trp_pkg::NUM_CH,
	parameter int RETRY_LIMIT = trp_pkg::RETRY_LIMIT
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Register port
	input wire trp_pkg::trp_bus_s bus_i,
	output logic [trp_pkg::DATA_W-1:0] rdata_o,
	// Host pins
	input wire logic [NUM_CH-1:0] parallel_input_pin_i,
	input wire logic limp_home_pin_i,
	// Analog indications
	input wire trp_pkg::trp_sense_s sense_i,
	// Outputs
	output logic [NUM_CH-1:0] channel_drive_o,
	output logic any_channel_latched_flag_o,
	output logic irq_o
);
	localparam int SENSE_W = $bits(trp_pkg::trp_sense_s);
	localparam int CW = trp_pkg::CNT_W;

	// -------------------------------------------------------------
	// Input synchronisation
	// -------------------------------------------------------------
	trp_pkg::trp_sense_s sense;
	logic limp;
	logic [NUM_CH-1:0] pin_sync;

	trp_sync #(
		.WIDTH(SENSE_W)
	) u_sense_sync (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.async_i(sense_i),
		.sync_o(sense)
	);

	trp_sync #(
		.WIDTH(NUM_CH + 1)
	) u_pin_sync (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.async_i({limp_home_pin_i, parallel_input_pin_i}),
		.sync_o({limp, pin_sync})
	);

	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	logic [NUM_CH-1:0] channel_on_bit;
	logic reactivation_counter_reset_bit;
	logic [trp_pkg::IRQ_W-1:0] irq_status;
	logic [trp_pkg::IRQ_W-1:0] irq_mask;

	// Address decode
	function automatic logic hit(input logic [trp_pkg::ADDR_W-1:0] a,
		input logic [trp_pkg::ADDR_W-1:0] b);
		hit = a == b;
	endfunction

	wire logic wr_ctrl = bus_i.wr && hit(bus_i.addr, trp_pkg::ADDR_CTRL);
	wire logic wr_cfg = bus_i.wr && hit(bus_i.addr, trp_pkg::ADDR_CFG);
	wire logic wr_stat = bus_i.wr && hit(bus_i.addr, trp_pkg::ADDR_IRQ_STAT);
	wire logic wr_mask = bus_i.wr && hit(bus_i.addr, trp_pkg::ADDR_IRQ_MASK);

	wire logic clear_thermal_counters_bit = wr_cfg && !limp &&
		bus_i.wdata[trp_pkg::CFG_CLEAR_BIT];

	// Control register writes
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			channel_on_bit <= trp_pkg::CH_ZERO;
			reactivation_counter_reset_bit <= 1'b0;
			irq_mask <= '0;
		end else begin
			if (wr_ctrl)
				channel_on_bit <= bus_i.wdata[NUM_CH-1:0];
			if (wr_cfg)
				reactivation_counter_reset_bit <=
					bus_i.wdata[trp_pkg::CFG_REACT_RST_BIT];
			if (wr_mask)
				irq_mask <= bus_i.wdata[trp_pkg::IRQ_W-1:0];
		end
	end

	// -------------------------------------------------------------
	// Channel sequencers
	// -------------------------------------------------------------
	logic [NUM_CH-1:0] ch_on;
	logic [NUM_CH-1:0] ch_latched;
	logic [NUM_CH-1:0] ch_trip;
	logic [NUM_CH*CW-1:0] ch_count;

	// limp-home forces OR of pins and bits
	// overvoltage has no effect on requests
	wire logic [NUM_CH-1:0] request = pin_sync | channel_on_bit;

	// limp counts only with logic supply
	wire logic count_enable = !limp || sense.logic_supply_ok;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			// clear returns a cooling or latched channel to off, request restarts it
			trp_channel #(
				.CNT_W(CW),
				.RETRY_LIMIT(RETRY_LIMIT)
			) u_ch (
				.mclk_i(mclk_i),
				.reset_n_i(reset_n_i),
				.request_i(request[g]),
				.trip_i(sense.abs_trip[g] | sense.dyn_trip[g]),
				.temp_ok_i(sense.temp_ok[g]),
				.supply_hold_ok_i(sense.supply_hold_ok),
				.supply_operate_ok_i(sense.supply_operate_ok),
				.count_enable_i(count_enable),
				.react_rst_i(reactivation_counter_reset_bit),
				.clear_i(clear_thermal_counters_bit),
				.on_o(ch_on[g]),
				.latched_o(ch_latched[g]),
				.trip_event_o(ch_trip[g]),
				.count_o(ch_count[g*CW +: CW])
			);
		end
	endgenerate

	// -------------------------------------------------------------
	// Interrupts
	// -------------------------------------------------------------
	logic [trp_pkg::IRQ_W-1:0] irq_event;
	logic latched_any_q;

	assign irq_event[trp_pkg::IRQ_LATCH] = |ch_latched && !latched_any_q;
	assign irq_event[trp_pkg::IRQ_TRIP] = |ch_trip;
	assign irq_event[trp_pkg::IRQ_UV] = !sense.supply_hold_ok && |ch_on;

	wire logic [trp_pkg::IRQ_W-1:0] w1c = wr_stat ?
		bus_i.wdata[trp_pkg::IRQ_W-1:0] : '0;

	// Sticky status, set beats write-one clear
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_status <= '0;
			latched_any_q <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~w1c) | irq_event;
			latched_any_q <= |ch_latched;
			irq_o <= |(((irq_status & ~w1c) | irq_event) & irq_mask);
		end
	end

	// -------------------------------------------------------------
	// Read data and outputs
	// -------------------------------------------------------------
	logic [trp_pkg::DATA_W-1:0] next_rdata;
	logic [trp_pkg::DATA_W-1:0] diag_word;
	logic [trp_pkg::DATA_W-1:0] count_word;

	// summary bit from any latched channel
	always_comb begin
		diag_word = trp_pkg::DATA_ZERO;
		diag_word[NUM_CH-1:0] = ch_on;
		diag_word[trp_pkg::DIAG_OT_LSB +: NUM_CH] = ch_latched;
		diag_word[trp_pkg::DIAG_SUMMARY_BIT] = |ch_latched;
		count_word = trp_pkg::DATA_ZERO;
		count_word[NUM_CH*CW-1:0] = ch_count;
	end

	always_comb begin
		next_rdata = trp_pkg::DATA_ZERO;
		if (bus_i.rd) begin
			case (bus_i.addr)
				trp_pkg::ADDR_CTRL:
					next_rdata[NUM_CH-1:0] = channel_on_bit;
				trp_pkg::ADDR_CFG:
					next_rdata[trp_pkg::CFG_REACT_RST_BIT] =
						reactivation_counter_reset_bit;
				trp_pkg::ADDR_DIAG: next_rdata = diag_word;
				trp_pkg::ADDR_IRQ_STAT:
					next_rdata[trp_pkg::IRQ_W-1:0] = irq_status;
				trp_pkg::ADDR_IRQ_MASK:
					next_rdata[trp_pkg::IRQ_W-1:0] = irq_mask;
				trp_pkg::ADDR_COUNT: begin
					next_rdata = count_word;
					next_rdata[trp_pkg::DATA_W-1 -: NUM_CH] = ch_latched;
				end
				default: next_rdata = trp_pkg::DATA_ZERO;
			endcase
		end
	end

	// Registered outputs
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= trp_pkg::DATA_ZERO;
			channel_drive_o <= trp_pkg::CH_ZERO;
			any_channel_latched_flag_o <= 1'b0;
		end else begin
			rdata_o <= next_rdata;
			channel_drive_o <= ch_on & {NUM_CH{sense.supply_hold_ok}};
			any_channel_latched_flag_o <= |ch_latched;
		end
	end
endmodule

// ==== test/trp_sensor_model.sv ====
`timescale 1ns/100ps
// ----
// Thermal and supply sensor model
// ----
module trp_sensor_model (
	// Clock and channel state
	input wire logic mclk_i,
	input wire logic [3:0] drive_i,
	// Scenario controls
	input wire logic [3:0] overload_i,
	input wire logic dyn_sel_i,
	input wire logic hold_ok_i,
	input wire logic op_ok_i,
	input wire logic lsup_ok_i,
	// Indications
	output trp_pkg::trp_sense_s sense_o
);
	logic [3:0] hot0 = 4'h0;
	logic [3:0] hot1 = 4'h0;
	logic [3:0] hot2 = 4'h0;

	// Overloaded driven channel heats up
	always @(posedge mclk_i) begin
		hot0 <= drive_i & overload_i;
		hot1 <= hot0;
		hot2 <= hot1;
	end

	assign sense_o.abs_trip = dyn_sel_i ? 4'h0 : hot0;
	assign sense_o.dyn_trip = dyn_sel_i ? hot0 : 4'h0;
	assign sense_o.temp_ok = ~(hot0 | hot1 | hot2);
	assign sense_o.supply_hold_ok = hold_ok_i;
	assign sense_o.supply_operate_ok = op_ok_i;
	assign sense_o.logic_supply_ok = lsup_ok_i;
endmodule

// ==== test/trp_top_checker.sv ====
`timescale 1ns/100ps
// ----
// Port checker
// ----
module trp_top_checker #(
	parameter int NUM_CH = 4,
	parameter int RETRY_LIMIT = 8
) (
	// Clock, reset, inputs
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire trp_pkg::trp_bus_s bus_i,
	input wire logic [NUM_CH-1:0] parallel_input_pin_i,
	input wire logic limp_home_pin_i,
	input wire trp_pkg::trp_sense_s sense_i,
	// Outputs
	input wire logic [trp_pkg::DATA_W-1:0] rdata_o,
	input wire logic [NUM_CH-1:0] channel_drive_o,
	input wire logic any_channel_latched_flag_o,
	input wire logic irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	// Decoded events
	wire logic clr_req = bus_i.wr && bus_i.addr == trp_pkg::ADDR_CFG
		&& bus_i.wdata[trp_pkg::CFG_CLEAR_BIT];
	wire logic trip0 = sense_i.abs_trip[0] | sense_i.dyn_trip[0];
	wire logic all_ok = sense_i.supply_hold_ok && sense_i.supply_operate_ok
		&& sense_i.abs_trip == '0 && sense_i.dyn_trip == '0;
	logic [4:0] clr_hist;

	// Recent clear requests
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			clr_hist <= 5'h00;
		else
			clr_hist <= {clr_hist[3:0], clr_req};
	end

	property p_trip_off;
		$rose(trip0) |-> ##[1:5] !channel_drive_o[0];
	endproperty
	a_trip_off: assert property (p_trip_off)
		else $error("channel stayed on after trip");
	property p_hold_off;
		!sense_i.supply_hold_ok [*5] |-> channel_drive_o == '0;
	endproperty
	a_hold_off: assert property (p_hold_off)
		else $error("channel on below hold level");
	property p_no_start;
		!sense_i.supply_operate_ok [*5] |-> !$rose(channel_drive_o[0]);
	endproperty
	a_no_start: assert property (p_no_start)
		else $error("channel started below operate level");
	property p_summary;
		bus_i.rd && bus_i.addr == trp_pkg::ADDR_DIAG
		&& any_channel_latched_flag_o && $past(any_channel_latched_flag_o)
		&& !$past(bus_i.wr) |=> rdata_o[trp_pkg::DIAG_SUMMARY_BIT];
	endproperty
	a_summary: assert property (p_summary)
		else $error("summary bit missing");
	property p_unmapped;
		bus_i.rd && bus_i.addr == 4'h3 |=> rdata_o == '0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_clear_on;
		!limp_home_pin_i [*4] ##0 (clr_req && all_ok
		&& parallel_input_pin_i == '1) |-> ##[1:6] channel_drive_o == '1;
	endproperty
	a_clear_on: assert property (p_clear_on)
		else $error("requested channels not on after clear");
	property p_fell;
		$fell(any_channel_latched_flag_o) |-> |clr_hist;
	endproperty
	a_fell: assert property (p_fell)
		else $error("latch left without clear");
	property p_limp_keep;
		limp_home_pin_i [*4] ##0 (clr_req && any_channel_latched_flag_o)
		|=> any_channel_latched_flag_o [*5];
	endproperty
	a_limp_keep: assert property (p_limp_keep)
		else $error("clear taken in limp mode");
endmodule

bind trp_top trp_top_checker #(.NUM_CH(NUM_CH), .RETRY_LIMIT(RETRY_LIMIT))
	u_chk (.mclk_i, .reset_n_i, .bus_i, .parallel_input_pin_i,
	.limp_home_pin_i, .sense_i, .rdata_o, .channel_drive_o,
	.any_channel_latched_flag_o, .irq_o);

// ==== test/trp_top_tb.sv ====
`timescale 1ns/100ps
// ----
// Testbench
// ----
module trp_top_tb;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	trp_pkg::trp_bus_s bus = '0;
	logic [3:0] pins = 4'h0;
	logic limp = 1'b0;
	logic [3:0] ovl = 4'h0;
	logic dyn = 1'b0;
	logic hold = 1'b1;
	logic op = 1'b1;
	logic lsup = 1'b1;
	trp_pkg::trp_sense_s sense;
	logic [31:0] rdata;
	logic [3:0] drive;
	logic flag;
	logic irq;
	logic [31:0] v;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	// Rows: pins, control bits, expected drive
	logic [11:0] rows [4] = '{12'h000, 12'h505, 12'h0AA, 12'h3CF};

	initial forever #20 mclk_i = ~mclk_i;

	trp_top u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_i(bus),
		.rdata_o(rdata), .parallel_input_pin_i(pins),
		.limp_home_pin_i(limp), .sense_i(sense), .channel_drive_o(drive),
		.any_channel_latched_flag_o(flag), .irq_o(irq));
	trp_sensor_model u_sens (.mclk_i(mclk_i), .drive_i(drive),
		.overload_i(ovl), .dyn_sel_i(dyn), .hold_ok_i(hold), .op_ok_i(op),
		.lsup_ok_i(lsup), .sense_o(sense));

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge mclk_i);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge mclk_i);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_flag(input logic val, input int n);
		for (int i = 0; i < n && flag !== val; i++)
			@(posedge mclk_i);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Hang guard
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end

	// Main sequence
	initial begin
		repeat (10) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		#1 chk("flag", {31'h0, flag}, 32'h0);
		rd(trp_pkg::ADDR_COUNT, v);
		chk("count", v, 32'h0);
		rd(4'h3, v);
		chk("unmapped", v, 32'h0);
		wr(trp_pkg::ADDR_IRQ_MASK, 32'h0);
		foreach (rows[i]) begin
			@(posedge mclk_i);
			pins <= rows[i][11:8];
			wr(trp_pkg::ADDR_CTRL, {28'h0, rows[i][7:4]});
			repeat (6) @(posedge mclk_i);
			chk("drive", {28'h0, drive}, {28'h0, rows[i][3:0]});
		end
		// Two channels overheat until latched
		pins <= 4'h0;
		wr(trp_pkg::ADDR_CTRL, 32'h3);
		dyn <= 1'b1;
		ovl <= 4'h3;
		wait_flag(1'b1, 400);
		repeat (40) @(posedge mclk_i);
		rd(trp_pkg::ADDR_DIAG, v);
		chk("diag", v & 32'h1FF, 32'h130);
		rd(trp_pkg::ADDR_COUNT, v);
		chk("count", v & 32'h300000FF, 32'h30000088);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(trp_pkg::ADDR_IRQ_MASK, 32'h7);
		repeat (3) @(posedge mclk_i);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(trp_pkg::ADDR_IRQ_MASK, 32'h0);
		wr(trp_pkg::ADDR_IRQ_STAT, 32'h7);
		repeat (3) @(posedge mclk_i);
		chk("irq", {31'h0, irq}, 32'h0);
		// Clear with all channels requested
		ovl <= 4'h0;
		pins <= 4'hF;
		repeat (5) @(posedge mclk_i);
		wr(trp_pkg::ADDR_CFG, 32'h1);
		repeat (8) @(posedge mclk_i);
		chk("drive", {28'h0, drive}, 32'hF);
		rd(trp_pkg::ADDR_COUNT, v);
		chk("count", v, 32'h0);
		// Counter reset on new activation
		wr(trp_pkg::ADDR_CFG, 32'h2);
		pins <= 4'h0;
		wr(trp_pkg::ADDR_CTRL, 32'h4);
		dyn <= 1'b0;
		ovl <= 4'h4;
		repeat (40) @(posedge mclk_i);
		ovl <= 4'h0;
		repeat (10) @(posedge mclk_i);
		wr(trp_pkg::ADDR_CTRL, 32'h0);
		repeat (6) @(posedge mclk_i);
		wr(trp_pkg::ADDR_CTRL, 32'h4);
		repeat (8) @(posedge mclk_i);
		rd(trp_pkg::ADDR_COUNT, v);
		chk("count2", {28'h0, v[11:8]}, 32'h0);
		wr(trp_pkg::ADDR_CFG, 32'h0);
		wr(trp_pkg::ADDR_CTRL, 32'h0);
		// Limp mode
		limp <= 1'b1;
		lsup <= 1'b0;
		pins <= 4'h8;
		repeat (8) @(posedge mclk_i);
		chk("drive", {28'h0, drive}, 32'h8);
		ovl <= 4'h8;
		repeat (300) @(posedge mclk_i);
		chk("flag", {31'h0, flag}, 32'h0);
		lsup <= 1'b1;
		wait_flag(1'b1, 400);
		chk("flag", {31'h0, flag}, 32'h1);
		wr(trp_pkg::ADDR_CFG, 32'h1);
		repeat (10) @(posedge mclk_i);
		chk("flag", {31'h0, flag}, 32'h1);
		limp <= 1'b0;
		ovl <= 4'h0;
		pins <= 4'h0;
		repeat (6) @(posedge mclk_i);
		wr(trp_pkg::ADDR_CFG, 32'h1);
		repeat (8) @(posedge mclk_i);
		chk("flag", {31'h0, flag}, 32'h0);
		// Supply dips
		wr(trp_pkg::ADDR_CTRL, 32'hF);
		repeat (8) @(posedge mclk_i);
		hold <= 1'b0;
		op <= 1'b0;
		repeat (6) @(posedge mclk_i);
		chk("drive", {28'h0, drive}, 32'h0);
		hold <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk("drive", {28'h0, drive}, 32'h0);
		op <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk("drive", {28'h0, drive}, 32'hF);
		rd(trp_pkg::ADDR_IRQ_STAT, v);
		chk("uv", v & 32'h4, 32'h4);
		final_report();
	end
endmodule
